// file: rtl/host_bus_chip_select_decode.v
// Host data-bus interface, internal cells, drive bit-7 path and chip-select outputs
`timescale 1ns/1ps
`include "host_bus_regs.vh"

module host_bus_chip_select_decode #(
   parameter RAM_DEPTH = 128                   // Clock-associated RAM locations
) (
   input  wire       mclk,                     // System clock, 20 MHz
   input  wire       sys_rst,                  // Asynchronous reset, active high
   input  wire       io_read,                  // I/O read strobe, active high
   input  wire       io_write,                 // I/O write strobe, active high
   input  wire       decode_enable,            // Decode enable from system controller
   input  wire       dma_ack_ignore,           // Ignore address inputs during DMA ack
   input  wire       page_decode_low,          // Address in x70-x77 block
   input  wire       page_decode_high,         // Address in xF0-xF7 block
   input  wire [2:0] upper_addr_bits,          // Address bits 10:8
   input  wire [2:0] addr_low,                 // Address bits 2:0
   input  wire       xfer_16bit,               // Current drive transfer is 16 bits
   input  wire [7:0] host_data_in,             // Host data bus, input side
   output reg  [7:0] host_data_out,            // Host data bus, output side
   output wire       host_data_oe_low,         // Drive enable for host bits 6:0
   output wire       host_data_bit7_oe,        // Drive enable for host bit 7
   input  wire       drive_port_bit7_in,       // Drive port bit 7, input side
   output reg        drive_port_bit7_out,      // Drive port bit 7, output side
   output wire       drive_port_bit7_oe,       // Drive port bit 7 enable
   input  wire       disk_change_status,       // Floppy disk-change status
   input  wire [7:0] fdc_main_status,          // Floppy main status from core
   input  wire [7:0] fdc_status,               // Floppy status from core
   output wire       drive_card_select_a,      // First drive card select
   output wire       drive_card_select_b,      // Second drive card select
   output wire       drive_xcvr_en_low_n,      // Low-byte transceiver enable, active low
   output wire       drive_xcvr_en_high_n,     // High-byte transceiver enable, active low
   output wire [1:0] mb_select,                // Motherboard chip selects
   output wire [7:0] fdc_oper,                 // Floppy operation cell to core
   output wire [7:0] fdc_ctrl,                 // Floppy control cell to core
   output wire [7:0] fdc_data_wr,              // Floppy data byte written by host
   output reg        fdc_data_wr_pulse,        // One-cycle pulse on data write
   output reg        fdc_data_rd_pulse         // One-cycle pulse on data read
);

   wire                     sel_rtc;
   wire                     sel_fdc;
   wire                     sel_ide_a;
   wire                     sel_ide_b;
   wire                     sel_alt;
   wire                     sel_internal;
   wire                     sel_drive;
   wire                     rd_internal;
   wire                     rd_drive_bit7;
   wire                     wr_fdc_oper;
   wire                     wr_fdc_ctrl;
   wire                     wr_fdc_data;
   wire                     rd_fdc_data;
   wire                     wr_rtc_index;
   wire                     wr_rtc_data;
   wire                     rtc_data_port;

   reg  [7:0]               oper_cell;
   reg  [7:0]               ctrl_cell;
   reg  [7:0]               data_cell;
   reg  [`RTC_ADDR_W-1:0]   rtc_index;
   reg  [7:0]               rtc_ram [0:RAM_DEPTH-1];
   reg  [7:0]               next_data_out;
   reg                      wr_seen;
   reg                      rd_seen;

   select_decoder i_select_decoder (
      .decode_enable    (decode_enable),
      .dma_ack_ignore   (dma_ack_ignore),
      .page_decode_low  (page_decode_low),
      .page_decode_high (page_decode_high),
      .upper_addr_bits  (upper_addr_bits),
      .addr_low         (addr_low),
      .sel_rtc          (sel_rtc),
      .sel_fdc          (sel_fdc),
      .sel_ide_a        (sel_ide_a),
      .sel_ide_b        (sel_ide_b),
      .sel_alt          (sel_alt),
      .mb_select        (mb_select)
   );

   // Address map carried by the decoder:
   //   x70 clock RAM index, x71 clock RAM data (low page, bits 10:8 = 0)
   //   3F1 status, 3F2 operation, 3F4 main status, 3F5 data, 3F7 control write
   //   3F6 and 3F7 also reach the drive auxiliary block through card select b
   //   1F0 to 1F7 reach the drive task file through card select a
   //   High page with bits 10:8 = 2 or 6 goes to the motherboard selects
   // The page decodes are trusted to qualify address bits 7:3 already.
   // Read enables follow the strobe at once, but the byte is registered, so
   // a host read must span at least one rising edge before data is valid.
   // A write held over several edges stores the same byte again; this is
   // harmless for the cells, and the core data pulses fire once per strobe.

   assign sel_internal = sel_rtc | sel_fdc;
   assign sel_drive    = sel_ide_a | sel_ide_b;

   assign drive_card_select_b  = sel_ide_b;
   // task file select, low and 16-bit high enables
   assign drive_card_select_a  = sel_ide_a;
   assign drive_xcvr_en_low_n  = ~sel_drive;
   assign drive_xcvr_en_high_n = ~(sel_ide_a & xfer_16bit);

   // release bits 6:0 outside internal reads
   assign rd_internal       = io_read & sel_internal;
   // bit 7 only for drive-decoded reads
   assign rd_drive_bit7     = io_read & sel_drive;
   assign host_data_oe_low  = rd_internal;
   assign host_data_bit7_oe = rd_internal | rd_drive_bit7;

   // drive the drive port only on drive writes
   assign drive_port_bit7_oe = io_write & sel_drive & ~io_read;

   assign rtc_data_port = (addr_low == `OFS_RTC_DATA);
   assign wr_fdc_oper   = io_write & sel_fdc & (addr_low == `OFS_FDC_OPER);
   assign wr_fdc_ctrl   = io_write & sel_fdc & sel_alt;
   assign wr_fdc_data   = io_write & sel_fdc & (addr_low == `OFS_FDC_DATA);
   assign rd_fdc_data   = io_read & sel_fdc & (addr_low == `OFS_FDC_DATA);
   assign wr_rtc_index  = io_write & sel_rtc & ~rtc_data_port;
   assign wr_rtc_data   = io_write & sel_rtc & rtc_data_port;

   assign fdc_oper    = oper_cell;
   assign fdc_ctrl    = ctrl_cell;
   assign fdc_data_wr = data_cell;

   // read multiplexer, byte from the addressed cell
   always @* begin
      next_data_out = 8'h00;
      if (sel_rtc) begin
         if (rtc_data_port) begin
            next_data_out = rtc_ram[rtc_index];
         end else begin
            next_data_out = {1'b0, rtc_index};
         end
      end else if (sel_fdc) begin
         case (addr_low)
            `OFS_FDC_STATUS: next_data_out = fdc_status;
            `OFS_FDC_OPER:   next_data_out = oper_cell;
            `OFS_FDC_MSTAT:  next_data_out = fdc_main_status;
            `OFS_FDC_DATA:   next_data_out = data_cell;
            // alternate address returns disk change on bit 7
            `OFS_IDE_ALT:    next_data_out = {disk_change_status, 7'h00};
            default:         next_data_out = 8'h00;
         endcase
      end else if (sel_drive) begin
         // drive bit 7 passed to host on drive reads other than 3F7
         next_data_out = {drive_port_bit7_in, 7'h00};
      end
   end

   // Output byte lags the select by one edge; strobes span several cycles
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         host_data_out       <= 8'h00;
         drive_port_bit7_out <= 1'b0;
      end else begin
         host_data_out <= next_data_out;
         // host bit 7 copied toward the drive
         if (io_write & sel_drive) begin
            drive_port_bit7_out <= host_data_in[7];
         end
      end
   end

   // writes into the floppy cells and RAM index
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         oper_cell <= `RST_FDC_OPER;
         ctrl_cell <= `RST_FDC_CTRL;
         data_cell <= `RST_FDC_DATA;
         rtc_index <= `RST_RTC_INDEX;
      end else begin
         if (wr_fdc_oper) begin
            oper_cell <= host_data_in;
         end
         if (wr_fdc_ctrl) begin
            ctrl_cell <= host_data_in;
         end
         if (wr_fdc_data) begin
            data_cell <= host_data_in;
         end
         if (wr_rtc_index) begin
            rtc_index <= host_data_in[`RTC_ADDR_W-1:0];
         end
      end
   end

   // RAM is not reset; contents survive like battery-backed cells
   always @(posedge mclk) begin
      if (wr_rtc_data) begin
         rtc_ram[rtc_index] <= host_data_in;
      end
   end

   // One pulse per strobe so the core sees each data byte once
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_seen           <= 1'b0;
         rd_seen           <= 1'b0;
         fdc_data_wr_pulse <= 1'b0;
         fdc_data_rd_pulse <= 1'b0;
      end else begin
         wr_seen           <= wr_fdc_data;
         rd_seen           <= rd_fdc_data;
         fdc_data_wr_pulse <= wr_fdc_data & ~wr_seen;
         fdc_data_rd_pulse <= rd_fdc_data & ~rd_seen;
      end
   end

endmodule // host_bus_chip_select_decode

// file: rtl/host_bus_regs.vh
// Address decode codes, register offsets and reset values for the host bus glue
`ifndef HOST_BUS_REGS_VH
`define HOST_BUS_REGS_VH

// Upper address bits 10:8 as seen inside each decoded block
`define UA_RTC_PAGE      3'h0
`define UA_IDE_PAGE      3'h1
`define UA_MB0_PAGE      3'h2
`define UA_FDC_PAGE      3'h3
`define UA_MB1_PAGE      3'h6

// Low address offsets inside the xF0-xF7 block of the floppy page
`define OFS_FDC_STATUS   3'h1
`define OFS_FDC_OPER     3'h2
`define OFS_FDC_MSTAT    3'h4
`define OFS_FDC_DATA     3'h5
`define OFS_IDE_AUX      3'h6
`define OFS_IDE_ALT      3'h7

// Offsets inside the x70-x77 block of the low page
`define OFS_RTC_INDEX    3'h0
`define OFS_RTC_DATA     3'h1

// Reset values of the stored cells
`define RST_FDC_OPER     8'h00
`define RST_FDC_CTRL     8'h00
`define RST_FDC_DATA     8'h00
`define RST_RTC_INDEX    7'h00

// Width of the clock-associated RAM index
`define RTC_ADDR_W       7

`endif

// file: rtl/select_decoder.v
// Chip-select decoder from page decodes and upper address bits
`timescale 1ns/1ps
`include "host_bus_regs.vh"

module select_decoder (
   input  wire       decode_enable,     // Decoded outputs allowed
   input  wire       dma_ack_ignore,    // Ignore page and address inputs
   input  wire       page_decode_low,   // Address in x70-x77 block
   input  wire       page_decode_high,  // Address in xF0-xF7 block
   input  wire [2:0] upper_addr_bits,   // Address bits 10:8
   input  wire [2:0] addr_low,          // Address bits 2:0
   output wire       sel_rtc,           // Clock RAM index/data port
   output wire       sel_fdc,           // Floppy register block
   output wire       sel_ide_a,         // Drive task file block
   output wire       sel_ide_b,         // Drive auxiliary block
   output wire       sel_alt,           // Alternate address xF7 of floppy page
   output wire [1:0] mb_select          // Motherboard selects
);

   wire       live;
   wire       fdc_pg;
   wire       aux_hit;

   // enable gating, ignore during DMA acknowledge
   assign live    = decode_enable & ~dma_ack_ignore;

   // decode from page and address bits
   assign fdc_pg  = live & page_decode_high & (upper_addr_bits == `UA_FDC_PAGE);
   assign aux_hit = (addr_low == `OFS_IDE_AUX) | (addr_low == `OFS_IDE_ALT);

   assign sel_rtc   = live & page_decode_low & (upper_addr_bits == `UA_RTC_PAGE)
                    & ((addr_low == `OFS_RTC_INDEX) | (addr_low == `OFS_RTC_DATA));
   assign sel_ide_a = live & page_decode_high & (upper_addr_bits == `UA_IDE_PAGE);
   assign sel_ide_b = fdc_pg & aux_hit;
   assign sel_alt   = fdc_pg & (addr_low == `OFS_IDE_ALT);
   assign sel_fdc   = fdc_pg & ((addr_low == `OFS_FDC_STATUS) | (addr_low == `OFS_FDC_OPER)
                    | (addr_low == `OFS_FDC_MSTAT) | (addr_low == `OFS_FDC_DATA)
                    | (addr_low == `OFS_IDE_ALT));
   assign mb_select[0] = live & page_decode_high & (upper_addr_bits == `UA_MB0_PAGE);
   assign mb_select[1] = live & page_decode_high & (upper_addr_bits == `UA_MB1_PAGE);

endmodule // select_decoder

// file: verif/host_bus_chip_select_decode_properties.sv
// Port-level checks of the host bus glue
`timescale 1ns/1ps
`include "host_bus_regs.vh"
module host_bus_chip_select_decode_chk (
   input wire       mclk, sys_rst, io_read, io_write, decode_enable, dma_ack_ignore,
   input wire       page_decode_high, xfer_16bit, disk_change_status, host_data_oe_low,
   input wire       drive_port_bit7_in, drive_port_bit7_out, drive_port_bit7_oe,
   input wire       drive_card_select_a, drive_card_select_b,
   input wire       drive_xcvr_en_low_n, drive_xcvr_en_high_n,
   input wire [2:0] upper_addr_bits, addr_low,
   input wire [1:0] mb_select,
   input wire [7:0] host_data_in, host_data_out, fdc_oper
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire live = decode_enable && !dma_ack_ignore && page_decode_high;
   wire none = !drive_card_select_a && !drive_card_select_b && mb_select == 2'h0;
   sequence s_fdc_page;
      live && upper_addr_bits == `UA_FDC_PAGE;
   endsequence
   sequence s_oper_wr;
      io_write && addr_low == `OFS_FDC_OPER ##0 s_fdc_page;
   endsequence
   sequence s_alt_rd;
      io_read && addr_low == `OFS_IDE_ALT ##0 s_fdc_page;
   endsequence
   property p_off; !decode_enable |-> none; endproperty
   a_off: assert property (p_off) else $error("select while decode disabled");
   property p_ign; dma_ack_ignore |-> none; endproperty
   a_ign: assert property (p_ign) else $error("select while ignoring inputs");
   property p_sel_a; live && upper_addr_bits == `UA_IDE_PAGE |-> drive_card_select_a; endproperty
   a_sel_a: assert property (p_sel_a) else $error("drive select a missing");
   property p_mb; live && upper_addr_bits == `UA_MB1_PAGE |-> mb_select == 2'h2; endproperty
   a_mb: assert property (p_mb) else $error("board select wrong");
   property p_low; drive_card_select_a || drive_card_select_b |-> !drive_xcvr_en_low_n; endproperty
   a_low: assert property (p_low) else $error("low enable missing");
   property p_high; drive_xcvr_en_high_n != (drive_card_select_a && xfer_16bit); endproperty
   a_high: assert property (p_high) else $error("high enable wrong");
   property p_wr7; io_write && drive_card_select_a |=> drive_port_bit7_out == $past(host_data_in[7]);
   endproperty
   a_wr7: assert property (p_wr7) else $error("drive bit 7 not written");
   property p_rd7; io_read && drive_card_select_a |=> host_data_out[7] == $past(drive_port_bit7_in);
   endproperty
   a_rd7: assert property (p_rd7) else $error("drive bit 7 not read");
   property p_alt; s_alt_rd |=> host_data_out == {$past(disk_change_status), 7'h00}; endproperty
   a_alt: assert property (p_alt) else $error("alternate read wrong");
   property p_oper; s_oper_wr |=> fdc_oper == $past(host_data_in); endproperty
   a_oper: assert property (p_oper) else $error("operation cell not written");
   property p_oe; host_data_oe_low |-> io_read; endproperty
   a_oe: assert property (p_oe) else $error("host bus driven without read");
   property p_d7;
      drive_port_bit7_oe |-> io_write && (drive_card_select_a || drive_card_select_b);
   endproperty
   a_d7: assert property (p_d7) else $error("drive bit 7 driven off a write");
endmodule // host_bus_chip_select_decode_chk
bind host_bus_chip_select_decode host_bus_chip_select_decode_chk i_chk (.*);

// file: verif/ide_bit7_drive.sv
// Drive-side model of the two-way bit-7 line
`timescale 1ns/1ps
module ide_bit7_drive (
   input  wire drive_port_bit7_out, // Bit 7 from the glue
   input  wire drive_port_bit7_oe,  // Glue drives the line
   input  wire drive_value,         // Level the drive puts out
   output wire drive_port_bit7_in   // Resolved line level
);
   // line resolution
   // The drive only talks once the glue lets go, so a stale bit cannot pass for data
   assign drive_port_bit7_in = drive_port_bit7_oe ? drive_port_bit7_out : drive_value;
endmodule // ide_bit7_drive

// file: verif/test_host_bus_chip_select_decode.sv
// Self-checking bench of the host bus glue
`timescale 1ns/1ps
`include "host_bus_regs.vh"
module test_host_bus_chip_select_decode;
   reg mclk = 1'b0, sys_rst = 1'b1, io_read = 1'b0, io_write = 1'b0, drive_value = 1'b0;
   reg decode_enable = 1'b1, dma_ack_ignore = 1'b0, page_decode_low = 1'b0;
   reg page_decode_high = 1'b0, xfer_16bit = 1'b0, disk_change_status = 1'b0;
   reg [2:0] upper_addr_bits = 3'h0, addr_low = 3'h0;
   reg [7:0] host_data_in = 8'h00, fdc_main_status = 8'h3c, fdc_status = 8'hc3;
   reg [7:0] snap, rd;
   reg       d7;
   reg [1:0] pl;
   wire [7:0] host_data_out, fdc_oper, fdc_ctrl, fdc_data_wr;
   wire [1:0] mb_select;
   wire host_data_oe_low, host_data_bit7_oe, drive_port_bit7_in, drive_port_bit7_out;
   wire drive_port_bit7_oe, drive_card_select_a, drive_card_select_b;
   wire drive_xcvr_en_low_n, drive_xcvr_en_high_n, fdc_data_wr_pulse, fdc_data_rd_pulse;
   wire [7:0] flags = {drive_card_select_a, drive_card_select_b, drive_xcvr_en_low_n,
      drive_xcvr_en_high_n, drive_port_bit7_oe, host_data_oe_low, host_data_bit7_oe, 1'b0};
   integer n_mismatch = 0, comparisons = 0, cycles = 0, k;
   always #25 mclk = ~mclk;
   host_bus_chip_select_decode #(.RAM_DEPTH(128)) i_host_bus_chip_select_decode (.mclk,
      .sys_rst, .io_read, .io_write, .decode_enable, .dma_ack_ignore, .page_decode_low,
      .page_decode_high, .upper_addr_bits, .addr_low, .xfer_16bit, .host_data_in,
      .host_data_out, .host_data_oe_low, .host_data_bit7_oe, .drive_port_bit7_in,
      .drive_port_bit7_out, .drive_port_bit7_oe, .disk_change_status, .fdc_main_status,
      .fdc_status, .drive_card_select_a, .drive_card_select_b, .drive_xcvr_en_low_n,
      .drive_xcvr_en_high_n, .mb_select, .fdc_oper, .fdc_ctrl, .fdc_data_wr,
      .fdc_data_wr_pulse, .fdc_data_rd_pulse);
   ide_bit7_drive i_ide_bit7_drive (.drive_port_bit7_out, .drive_port_bit7_oe,
      .drive_value, .drive_port_bit7_in);
   task end_of_test;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
         if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input string nm, input [7:0] exp, input [7:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // One strobe cycle, then one idle cycle so strobes never toggle within a time step
   task acc(input w, input h, input [2:0] u, input [2:0] l, input [7:0] d);
      begin
         io_write = w; io_read = !w; page_decode_high = h; page_decode_low = !h;
         upper_addr_bits = u; addr_low = l; host_data_in = d;
         #1 snap = flags;
         @(posedge mclk); #2 rd = host_data_out; d7 = drive_port_bit7_out;
         pl = {fdc_data_wr_pulse, fdc_data_rd_pulse};
         io_write = 1'b0; io_read = 1'b0;
         @(posedge mclk); #2;
      end
   endtask
   task t_decode;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            decode_enable = k[0]; dma_ack_ignore = k[1];
            acc(1'b0, 1'b1, `UA_IDE_PAGE, 3'h0, 8'h00);
            chk("select flags", (k == 1) ? 8'h92 : 8'h30, snap);
         end
         decode_enable = 1'b1; dma_ack_ignore = 1'b0;
         acc(1'b0, 1'b1, 3'h5, 3'h0, 8'h00);
         chk("unmapped flags", 8'h30, snap);
         acc(1'b0, 1'b1, `UA_MB0_PAGE, 3'h0, 8'h00);
         chk("board select 0", 8'h01, {6'h00, mb_select});
         acc(1'b0, 1'b1, `UA_MB1_PAGE, 3'h0, 8'h00);
         chk("board select 1", 8'h02, {6'h00, mb_select});
         $display("t_decode done");
      end
   endtask
   task t_cells;
      begin
         chk("oper reset", 8'h00, fdc_oper);
         acc(1'b1, 1'b1, `UA_FDC_PAGE, `OFS_FDC_OPER, 8'h5a);
         chk("oper cell", 8'h5a, fdc_oper);
         acc(1'b0, 1'b1, `UA_FDC_PAGE, `OFS_FDC_OPER, 8'h00);
         chk("oper readback", 8'h5a, rd);
         acc(1'b1, 1'b1, `UA_FDC_PAGE, `OFS_IDE_ALT, 8'h4b);
         chk("control cell", 8'h4b, fdc_ctrl);
         chk("control write flags", 8'h58, snap);
         acc(1'b1, 1'b1, `UA_FDC_PAGE, `OFS_FDC_DATA, 8'h96);
         chk("data cell", 8'h96, fdc_data_wr);
         chk("data write pulse", 8'h02, {6'h00, pl});
         chk("data pulse ends", 8'h00, {6'h00, fdc_data_wr_pulse, fdc_data_rd_pulse});
         acc(1'b0, 1'b1, `UA_FDC_PAGE, `OFS_FDC_DATA, 8'h00);
         chk("data readback", 8'h96, rd);
         chk("data read pulse", 8'h01, {6'h00, pl});
         acc(1'b0, 1'b1, `UA_FDC_PAGE, `OFS_FDC_MSTAT, 8'h00);
         chk("main status", 8'h3c, rd);
         acc(1'b0, 1'b1, `UA_FDC_PAGE, `OFS_FDC_STATUS, 8'h00);
         chk("status", 8'hc3, rd);
         acc(1'b1, 1'b0, `UA_RTC_PAGE, `OFS_RTC_INDEX, 8'h7f);
         acc(1'b1, 1'b0, `UA_RTC_PAGE, `OFS_RTC_DATA, 8'ha5);
         acc(1'b1, 1'b0, `UA_RTC_PAGE, `OFS_RTC_INDEX, 8'h00);
         acc(1'b1, 1'b0, `UA_RTC_PAGE, `OFS_RTC_DATA, 8'h3c);
         acc(1'b1, 1'b0, `UA_RTC_PAGE, `OFS_RTC_INDEX, 8'h7f);
         acc(1'b0, 1'b0, `UA_RTC_PAGE, `OFS_RTC_DATA, 8'h00);
         chk("ram top cell", 8'ha5, rd);
         chk("ram read flags", 8'h36, snap);
         acc(1'b0, 1'b0, `UA_RTC_PAGE, `OFS_RTC_INDEX, 8'h00);
         chk("ram index", 8'h7f, rd);
         $display("t_cells done");
      end
   endtask
   task t_drive;
      begin
         xfer_16bit = 1'b1;
         acc(1'b1, 1'b1, `UA_IDE_PAGE, 3'h0, 8'h80);
         chk("drive write flags", 8'h88, snap);
         chk("drive bit 7 out", 8'h01, {7'h00, d7});
         xfer_16bit = 1'b0;
         acc(1'b0, 1'b1, `UA_IDE_PAGE, 3'h0, 8'h00);
         chk("drive read low", 8'h00, {7'h00, rd[7]});
         drive_value = 1'b1;
         acc(1'b0, 1'b1, `UA_IDE_PAGE, 3'h3, 8'h00);
         chk("drive read high", 8'h01, {7'h00, rd[7]});
         $display("t_drive done");
      end
   endtask
   task t_alt;
      begin
         disk_change_status = 1'b1; drive_value = 1'b0;
         acc(1'b0, 1'b1, `UA_FDC_PAGE, `OFS_IDE_ALT, 8'h00);
         chk("alt read", 8'h80, rd);
         chk("alt flags", 8'h56, snap);
         disk_change_status = 1'b0; drive_value = 1'b1;
         acc(1'b0, 1'b1, `UA_FDC_PAGE, `OFS_IDE_ALT, 8'h00);
         chk("alt read clear", 8'h00, rd);
         $display("t_alt done");
      end
   endtask
   // Reset in mid-run clears the cells and index but leaves the clock RAM alone
   task t_reset;
      begin
         sys_rst = 1'b1;
         @(posedge mclk); #2;
         chk("oper after reset", 8'h00, fdc_oper);
         chk("control after reset", 8'h00, fdc_ctrl);
         chk("data after reset", 8'h00, fdc_data_wr);
         chk("bus byte after reset", 8'h00, host_data_out);
         chk("drive bit 7 after reset", 8'h00, {7'h00, drive_port_bit7_out});
         sys_rst = 1'b0;
         @(posedge mclk); #2;
         acc(1'b0, 1'b0, `UA_RTC_PAGE, `OFS_RTC_INDEX, 8'h00);
         chk("index after reset", 8'h00, rd);
         acc(1'b1, 1'b0, `UA_RTC_PAGE, `OFS_RTC_INDEX, 8'h7f);
         acc(1'b0, 1'b0, `UA_RTC_PAGE, `OFS_RTC_DATA, 8'h00);
         chk("ram kept over reset", 8'ha5, rd);
         $display("t_reset done");
      end
   endtask
   always @(posedge mclk) begin
      cycles = cycles + 1;
      if (cycles == 1000) begin
         n_mismatch = n_mismatch + 1;
         end_of_test;
      end
   end
   initial begin
      repeat (6) @(posedge mclk);
      #2 sys_rst = 1'b0;
      @(posedge mclk); #2;
      t_decode;
      t_cells;
      t_drive;
      t_alt;
      t_reset;
      end_of_test;
   end
endmodule // test_host_bus_chip_select_decode
